// ---- src/test_mode_pkg.sv ----
// Package: register map, field encodings and timing for the test-mode block
package test_mode_pkg;
  localparam int          N_IN            = 8;
  localparam int          N_OUT           = 8;
  localparam int          N_OPND          = 8;
  localparam int          OPND_W          = 4;
  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_IN_FORCE   = 8'h04;
  localparam logic [7:0]  ADDR_OUT_FORCE  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
  localparam logic [7:0]  ADDR_IN_STATE   = 8'h10;
  localparam logic [7:0]  ADDR_OUT_STATE  = 8'h14;
  // Control fields
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_SEL_LSB    = 4;
  localparam logic [3:0]  SEL_CONST_ON    = 4'hF;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_00F0;
  localparam logic [31:0] FORCE_RESET     = 32'h0000_0000;
  // Force encodings, two bits per contact
  localparam logic [1:0]  IN_DISABLED     = 2'h0;
  localparam logic [1:0]  IN_OPEN         = 2'h1;
  localparam logic [1:0]  IN_CLOSED       = 2'h2;
  localparam logic [1:0]  OUT_DISABLED    = 2'h0;
  localparam logic [1:0]  OUT_ENERGIZE    = 2'h1;
  localparam logic [1:0]  OUT_DEENERGIZE  = 2'h2;
  localparam logic [1:0]  OUT_FREEZE      = 2'h3;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // Indicator flash half period
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          FLASH_HALF_MS   = 250;
  localparam int          FLASH_CYCLES    = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int          FLASH_W         = 24;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_TEST = 2'b11
  } mode_state_t;
endpackage

// ---- src/pin_sync3.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree
`default_nettype none
module pin_sync3 import test_mode_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1, s2, s3, held;
  logic [W-1:0] next_held;

  always_comb begin
    next_held = held;
    for (int k = 0; k < W; k++) begin
      if (s2[k] == s3[k]) begin
        next_held[k] = s3[k];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      held <= '0;
    end else begin
      s1   <= i_async;
      s2   <= s1;
      s3   <= s2;
      held <= next_held;
    end
  end

  assign o_sync = held;
endmodule
`default_nettype wire

// ---- src/test_mode_io.sv ----
// Test-mode controller forcing contact inputs and outputs
// Notes on behaviour
// RULE_01: Test mode holds only while enabled and the chosen initiate is 1.
// RULE_02: A flashing indicator output runs while test mode is active.
// RULE_03: With the constant-on initiate, test begins on the enable edge.
// RULE_04: With an operand initiate, test begins when that operand goes 1.
// RULE_05: Nothing but contact input reports and output drives is altered.
// RULE_06: Every input and output has its own forcing selection.
// RULE_07: A disabled input reports its sensed terminal state.
// RULE_08: An input set open reports 0 throughout test mode.
// RULE_09: An input set closed reports 1 throughout test mode.
// RULE_10: With all input selections disabled every input reports live.
// RULE_11: A disabled output follows its operand, 1 operate, 0 reset.
// RULE_12: An output set energize is closed throughout test mode.
// RULE_13: An output set de-energize is open throughout test mode.
// RULE_14: An output set freeze keeps its state from test entry to exit.
// RULE_15: Outside test mode inputs report live and outputs follow operands.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module test_mode_io import test_mode_pkg::*; (
  input  wire logic               i_sys_clk,
  input  wire logic               i_rstn,
  // AXI4-Lite slave
  input  wire logic [7:0]         i_awaddr,
  input  wire logic               i_awvalid,
  output logic                    o_awready,
  input  wire logic [31:0]        i_wdata,
  input  wire logic [3:0]         i_wstrb,
  input  wire logic               i_wvalid,
  output logic                    o_wready,
  output logic [1:0]              o_bresp,
  output logic                    o_bvalid,
  input  wire logic               i_bready,
  input  wire logic [7:0]         i_araddr,
  input  wire logic               i_arvalid,
  output logic                    o_arready,
  output logic [31:0]             o_rdata,
  output logic [1:0]              o_rresp,
  output logic                    o_rvalid,
  input  wire logic               i_rready,
  // Contacts and logic operands
  input  wire logic [N_IN-1:0]    i_contact_sense,
  input  wire logic [N_OUT-1:0]   i_out_operand,
  input  wire logic [N_OPND-1:0]  i_initiate_operand,
  output logic [N_IN-1:0]         o_contact_state,
  output logic [N_OUT-1:0]        o_contact_drive,
  output logic                    o_test_led,
  output logic                    o_test_active
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl, in_force, out_force;
  logic [31:0] next_ctrl, next_in_force, next_out_force;
  logic        aw_held, w_held, bvalid, arready, rvalid;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic        awready, wready, next_awready, next_wready, next_arready;
  logic [7:0]  awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata, rdata, next_rdata;
  logic [3:0]  wstrb, next_wstrb;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [N_IN-1:0]  sensed, in_state, next_in_state;
  logic [N_OUT-1:0] drive, next_drive, frozen, next_frozen;
  mode_state_t      state, next_state;
  logic             test_on, next_test_on, led, next_led;
  logic [FLASH_W-1:0] flash_cnt, next_flash_cnt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_aw_held   = aw_held;
    next_w_held    = w_held;
    next_awaddr    = awaddr;
    next_wdata     = wdata;
    next_wstrb     = wstrb;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_ctrl      = ctrl;
    next_in_force  = in_force;
    next_out_force = out_force;
    if (i_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_awaddr  = i_awaddr;
    end
    if (i_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_wdata  = i_wdata;
      next_wstrb  = i_wstrb;
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    // Commit once both halves are held and no response is pending
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (awaddr)
        ADDR_CTRL:      next_ctrl      = merge(ctrl, wdata, wstrb);
        ADDR_IN_FORCE:  next_in_force  = merge(in_force, wdata, wstrb); // [RULE_06]
        ADDR_OUT_FORCE: next_out_force = merge(out_force, wdata, wstrb); // [RULE_06]
        ADDR_STATUS, ADDR_IN_STATE, ADDR_OUT_STATE: next_bresp = RESP_OKAY;
        default:        next_bresp     = RESP_SLVERR;
      endcase
    end
    // Ready comes from a flop so the port carries no decode
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
  end

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (i_araddr)
        ADDR_CTRL:      next_rdata = ctrl;
        ADDR_IN_FORCE:  next_rdata = in_force;
        ADDR_OUT_FORCE: next_rdata = out_force;
        ADDR_STATUS:    next_rdata = {30'h0, led, test_on};
        ADDR_IN_STATE:  next_rdata = {24'h0, in_state};
        ADDR_OUT_STATE: next_rdata = {24'h0, drive};
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awaddr    <= 8'h00;
      wdata     <= 32'h0000_0000;
      wstrb     <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= RESP_OKAY;
      arready   <= 1'b0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      ctrl      <= CTRL_RESET;
      in_force  <= FORCE_RESET;
      out_force <= FORCE_RESET;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      awaddr    <= next_awaddr;
      wdata     <= next_wdata;
      wstrb     <= next_wstrb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      // Ready only while no read answer is outstanding
      arready   <= next_arready;
      awready   <= next_awready;
      wready    <= next_wready;
      ctrl      <= next_ctrl;
      in_force  <= next_in_force;
      out_force <= next_out_force;
    end
  end

  // ----------------------------------------------------------------
  // Test mode sequencing
  // ----------------------------------------------------------------
  logic             enable, initiate, enable_q, next_enable_q;
  logic [OPND_W-1:0] sel;
  assign enable = ctrl[CTRL_EN_BIT];
  assign sel    = ctrl[CTRL_SEL_LSB +: OPND_W];
  // Unknown operand numbers never initiate
  assign initiate = (sel == SEL_CONST_ON) ? 1'b1 :
                    (int'(sel) < N_OPND) ? i_initiate_operand[sel[2:0]] :
                    1'b0;

  always_comb begin
    next_state    = state;
    next_enable_q = enable;
    unique case (state)
      ST_IDLE: begin
        // Constant-on starts only on the enable edge, not a held enable
        if (enable && !enable_q && initiate) begin
          next_state = ST_TEST; // [RULE_03]
        end else if (enable && sel != SEL_CONST_ON) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!enable || sel == SEL_CONST_ON) begin
          next_state = ST_IDLE;
        end else if (initiate) begin
          next_state = ST_TEST; // [RULE_04]
        end
      end
      ST_TEST: begin
        if (!enable || !initiate) begin
          next_state = ST_IDLE; // [RULE_01]
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_test_on = (next_state == ST_TEST);
  end

  always_comb begin
    next_flash_cnt = flash_cnt + 1'b1;
    next_led       = led;
    // Cleared on the exit edge so the indicator never outlives test mode
    if (!next_test_on) begin
      next_flash_cnt = '0;
      next_led       = 1'b0;
    end else if (int'(flash_cnt) == FLASH_CYCLES - 1) begin
      next_flash_cnt = '0;
      next_led       = !led; // [RULE_02]
    end
  end

  // ----------------------------------------------------------------
  // Contact forcing
  // ----------------------------------------------------------------
  pin_sync3 #(.W(N_IN)) u_sense_sync (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_async   (i_contact_sense),
    .o_sync    (sensed)
  );

  // Only the contacts are touched; other logic lives outside this block
  for (genvar g = 0; g < N_IN; g++) begin : g_in // [RULE_05]
    logic [1:0] fs;
    assign fs = in_force[2*g +: 2];
    always_comb begin
      next_in_state[g] = sensed[g]; // [RULE_07] [RULE_10] [RULE_15]
      if (test_on && fs == IN_OPEN) begin
        next_in_state[g] = 1'b0; // [RULE_08]
      end else if (test_on && fs == IN_CLOSED) begin
        next_in_state[g] = 1'b1; // [RULE_09]
      end
    end
  end

  for (genvar g = 0; g < N_OUT; g++) begin : g_out
    logic [1:0] fs;
    assign fs = out_force[2*g +: 2];
    always_comb begin
      next_drive[g]  = i_out_operand[g]; // [RULE_11] [RULE_15]
      if (test_on) begin
        unique case (fs)
          OUT_ENERGIZE:   next_drive[g] = 1'b1; // [RULE_12]
          OUT_DEENERGIZE: next_drive[g] = 1'b0; // [RULE_13]
          OUT_FREEZE:     next_drive[g] = frozen[g]; // [RULE_14]
          OUT_DISABLED:   next_drive[g] = i_out_operand[g];
        endcase
      end
      // Snapshot follows the driven value, so entry holds it with no step
      next_frozen[g] = test_on ? frozen[g] : next_drive[g]; // [RULE_14]
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state     <= ST_IDLE;
      test_on   <= 1'b0;
      enable_q  <= 1'b0;
      flash_cnt <= '0;
      led       <= 1'b0;
      in_state  <= '0;
      drive     <= '0;
      frozen    <= '0;
    end else begin
      state     <= next_state;
      test_on   <= next_test_on;
      enable_q  <= next_enable_q;
      flash_cnt <= next_flash_cnt;
      led       <= next_led;
      in_state  <= next_in_state;
      drive     <= next_drive;
      frozen    <= next_frozen;
    end
  end

  assign o_awready       = awready;
  assign o_wready        = wready;
  assign o_bvalid        = bvalid;
  assign o_bresp         = bresp;
  assign o_arready       = arready;
  assign o_rvalid        = rvalid;
  assign o_rdata         = rdata;
  assign o_rresp         = rresp;
  assign o_contact_state = in_state;
  assign o_contact_drive = drive;
  assign o_test_led      = led;
  assign o_test_active   = test_on;
endmodule
`default_nettype wire

// ---- verif/field_circuits.sv ----
// Behavioural model of the field wiring on the contact terminals
`default_nettype none
module field_circuits import test_mode_pkg::*; (
  input  wire logic [N_IN-1:0]  i_field_level,
  input  wire logic [N_OUT-1:0] i_contact_drive,
  output logic      [N_IN-1:0]  o_contact_sense,
  output logic      [N_OUT-1:0] o_load_energized
);
  timeunit 1ns;
  timeprecision 1ns;
  // Terminal voltage moves with no relation to the relay clock
  assign #7 o_contact_sense = i_field_level;
  // Loads settle a little after the contact moves
  assign #3 o_load_energized = i_contact_drive;
endmodule
`default_nettype wire

// ---- verif/test_mode_io_assertions.sv ----
// Port-level checker for the test-mode block
`default_nettype none
module test_mode_io_checker import test_mode_pkg::*; (
  input wire logic              i_sys_clk,
  input wire logic              i_rstn,
  input wire logic [7:0]        i_awaddr,
  input wire logic              i_awvalid,
  input wire logic              o_awready,
  input wire logic [31:0]       i_wdata,
  input wire logic [3:0]        i_wstrb,
  input wire logic              i_wvalid,
  input wire logic              o_wready,
  input wire logic [7:0]        i_araddr,
  input wire logic              i_arvalid,
  input wire logic              o_arready,
  input wire logic [31:0]       o_rdata,
  input wire logic [1:0]        o_rresp,
  input wire logic              o_rvalid,
  input wire logic [N_IN-1:0]   i_contact_sense,
  input wire logic [N_OUT-1:0]  i_out_operand,
  input wire logic [N_IN-1:0]   o_contact_state,
  input wire logic [N_OUT-1:0]  o_contact_drive,
  input wire logic              o_test_led,
  input wire logic              o_test_active
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Helper: cycles with steady terminals outside test mode
  // ----------------------------------------------------------------
  logic [3:0] quiet;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn || o_test_active || $changed(i_contact_sense)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ctrl_disable_exit: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready && i_wstrb[0] &&
    i_awaddr == ADDR_CTRL && !i_wdata[CTRL_EN_BIT] |-> ##[1:5] !o_test_active)
    else $error("test mode outlived a disable write");
  a_status_read: assert property (
    i_arvalid && o_arready && i_araddr == ADDR_STATUS
    |=> o_rvalid && o_rdata[0] == $past(o_test_active))
    else $error("status bit disagrees with test mode");
  a_drive_follows: assert property (
    $past(i_rstn) && !o_test_active && !$past(o_test_active)
    |-> o_contact_drive == $past(i_out_operand))
    else $error("output drive not following operand");
  // Sync stages need about five edges, so eight steady cycles is safe
  a_inputs_live: assert property (
    quiet >= 4'h8 |-> o_contact_state == i_contact_sense)
    else $error("reported input differs from terminal");
  a_led_idle: assert property (
    !o_test_active && !$past(o_test_active) |-> !o_test_led)
    else $error("indicator active outside test mode");
  a_led_only_test: assert property (
    $changed(o_test_led) |-> o_test_active || $past(o_test_active))
    else $error("indicator toggled outside test mode");
  a_ar_blocked: assert property (
    o_rvalid |-> !o_arready)
    else $error("read address accepted while data pending");
  a_unmapped_read: assert property (
    i_arvalid && o_arready && i_araddr > ADDR_OUT_STATE
    |=> o_rvalid && o_rresp == RESP_SLVERR && o_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind test_mode_io test_mode_io_checker i_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_awaddr(i_awaddr),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
  .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
  .i_contact_sense(i_contact_sense), .i_out_operand(i_out_operand),
  .o_contact_state(o_contact_state), .o_contact_drive(o_contact_drive),
  .o_test_led(o_test_led), .o_test_active(o_test_active)
);
`default_nettype wire

// ---- verif/test_mode_io_tb.sv ----
// Self-checking testbench for the test-mode block
`default_nettype none
module test_mode_io_tb import test_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, led, active;
  logic [7:0]  awaddr, araddr, field, operand, initiate;
  logic [7:0]  state, drive, sense, load;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          mismatches, check_count;
  test_mode_io i_test_mode_io (
    .i_sys_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_contact_sense(sense), .i_out_operand(operand),
    .i_initiate_operand(initiate), .o_contact_state(state),
    .o_contact_drive(drive), .o_test_led(led), .o_test_active(active));
  field_circuits i_field_circuits (.i_field_level(field),
    .i_contact_drive(drive), .o_contact_sense(sense),
    .o_load_energized(load));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Every polling loop goes through here so none can hang the run
  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 100) begin
      mismatches++;
      $display("[ERR] %0t wait ran out", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      step(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic wait_active(input logic v);
    int n;
    n = 0;
    while (active !== v) step(n);
    chk({31'h0, active}, {31'h0, v});
    // Mode follows its condition one edge later, seen here within two
    chk({31'h0, n <= 2}, 32'h1);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    field = 8'h5A;
    operand = 8'h3C;
    initiate = 8'h00;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    rd(ADDR_IN_FORCE, FORCE_RESET, RESP_OKAY);
    rd(ADDR_OUT_FORCE, FORCE_RESET, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h3, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    // Inputs: live, open, closed, code 3; outputs: freeze, off, on, live
    wr(ADDR_IN_FORCE, 32'hE4, RESP_OKAY);
    wr(ADDR_OUT_FORCE, 32'h1B, RESP_OKAY);
    rd(ADDR_IN_STATE, 32'h5A, RESP_OKAY);
    chk({24'h0, load}, 32'h3C);
    wr(ADDR_CTRL, 32'hF1, RESP_OKAY);
    wait_active(1'b1);
    field <= 8'h0B;
    operand <= 8'hFB;
    repeat (8) @(posedge clk);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    rd(ADDR_IN_STATE, 32'h0D, RESP_OKAY);
    rd(ADDR_OUT_STATE, 32'hFC, RESP_OKAY);
    chk({24'h0, load}, 32'hFC);
    wr(ADDR_CTRL, 32'hF0, RESP_OKAY);
    wait_active(1'b0);
    rd(ADDR_IN_STATE, 32'h0B, RESP_OKAY);
    rd(ADDR_OUT_STATE, 32'hFB, RESP_OKAY);
    // Operand two initiates; enable alone must not start test mode
    wr(ADDR_CTRL, 32'h21, RESP_OKAY);
    repeat (6) @(posedge clk);
    chk({31'h0, active}, 32'h0);
    initiate <= 8'h04;
    wait_active(1'b1);
    wr(ADDR_IN_FORCE, 32'h0, RESP_OKAY);
    repeat (8) @(posedge clk);
    rd(ADDR_IN_STATE, 32'h0B, RESP_OKAY);
    rd(ADDR_OUT_STATE, 32'hFD, RESP_OKAY);
    initiate <= 8'h00;
    wait_active(1'b0);
    conclude();
  end
endmodule
`default_nettype wire
